//--- iavs_defs.svh
/*
 * Constants of the interrupt acknowledge and vector sequencer: register
 * offsets, field positions, reset values and fixed encodings.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef IAVS_DEFS_SVH
`define IAVS_DEFS_SVH

// Register byte offsets on the bus; only haddr[7:0] is decoded.
`define IAVS_OFS_INIT_ONE 8'h00
`define IAVS_OFS_INIT_TWO 8'h04
`define IAVS_OFS_INIT_FOUR 8'h08
`define IAVS_OFS_MASK 8'h0C
`define IAVS_OFS_EOS_CMD 8'h10
`define IAVS_OFS_STATUS 8'h14

// Field positions inside the first initialization word.
`define IAVS_W1_ADDR_HI 7
`define IAVS_W1_ADDR_LO 5
`define IAVS_W1_SPACING 2
`define IAVS_W1_NEED_FOUR 0

// Field positions inside the fourth initialization word.
`define IAVS_W4_AUTO_EOS 1
`define IAVS_W4_POINTER 0

// Reset values.
`define IAVS_RST_BYTE 8'h00
`define IAVS_RST_WORD 32'h0000_0000

// Fixed encodings of the acknowledge sequence.
`define IAVS_CALL_OPCODE 8'hCD
`define IAVS_DROP_LEVEL 3'h7
`define IAVS_CALL_PULSES 2'h3
`define IAVS_PTR_PULSES 2'h2
`define IAVS_PULSE_ONE 2'h1
`define IAVS_PULSE_TWO 2'h2
`define IAVS_PULSE_THREE 2'h3
`define IAVS_CNT_ZERO 2'h0

// AHB encodings used by the slave.
`define IAVS_HTRANS_NONSEQ_BIT 1
`define IAVS_HRESP_OKAY 1'b0

`endif

//--- iavs_pkg.sv
/*
 * Types shared by the interrupt acknowledge and vector sequencer.
 * Assumes iavs_defs.svh is reachable on the include path.
 */
`include "iavs_defs.svh"

package iavs_pkg;

   // Sequencer states, binary codes written out.
   typedef enum logic [1:0]
   {
      IAVS_ST_IDLE = 2'b00,
      IAVS_ST_PULSE = 2'b01,
      IAVS_ST_GAP = 2'b10
   } iavs_state_t;

   // First initialization word as held by the block.
   typedef struct packed {
      logic [2:0] addrLow;
      logic spacingFour;
      logic needWordFour;
   } iavs_word_one_t;

   // Fourth initialization word as held by the block.
   typedef struct packed {
      logic autoEndOfService;
      logic pointerMode;
   } iavs_word_four_t;

   // Bus address phase captured for the data phase.
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic valid;
   } iavs_addr_phase_t;

endpackage : iavs_pkg

//--- iavs_sync.sv
/*
 * Two flip-flop level synchroniser with a per-bit reset value.
 * Assumes inputs are asynchronous levels; only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none

module iavs_sync
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stageOne_q;

   // The first stage is read by the second stage only.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stageOne_q <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         stageOne_q <= async_in;
         sync_out <= stageOne_q;
      end
   end

endmodule : iavs_sync

`default_nettype wire

//--- iavs_sequencer.sv
/*
 * Interrupt request latching and acknowledge sequencing for eight levels,
 * with an AHB-Lite slave holding the initialization words, mask, end of
 * service command and status. Assumes one clock, the acknowledge pin
 * active low, and a single AHB-Lite master doing single word transfers.
 */
// Notes on behaviour
// R1 - A rising request input sets its own request latch bit.
// R2 - Interrupt output rises only for an unmasked request above in-service.
// R3 - Call mode takes three pulses; first pulse drives opcode 0xCD.
// R4 - Call mode: second pulse low vector byte, third pulse high byte.
// R5 - Low byte: spacing 4 uses A7-A5 and D4-D2; spacing 8 A7-A6, D5-D3.
// R6 - Third pulse drives A15-A8 unchanged on D7-D0.
// R7 - Call mode third pulse sets in-service bit, clears request bit.
// R8 - Call mode auto end clears in-service at third pulse trailing edge.
// R9 - Pointer mode leaves the data bus undriven on the first pulse.
// R10 - Pointer mode second pulse drives the eight-bit type pointer.
// R11 - Pointer is type bits on D7-D3, level on D2-D0.
// R12 - Pointer mode auto end clears in-service at second trailing edge.
// R13 - The source holds its request high until the first pulse.
// R14 - A request dropped before the first pulse answers as level 7, unserved.
// R15 - Fourth word sets mode and auto end, only when first word asks.
// R16 - Second word gives A15-A8 or type bits.
// R17 - First word gives A7-A5 and the vector spacing.
// R18 - The highest unmasked pending level is the one reported.
// R19 - Requests and acknowledge are synchronised; pulses counted by edges.
`timescale 1ns/1ps
`default_nettype none
`include "iavs_defs.svh"

module iavs_sequencer
   import iavs_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [7:0] request_input,
   input wire logic irq_ack_pulse_n,
   output logic intOut,
   output logic [7:0] dataOut,
   output logic dataOe
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Lowest set index wins; level 0 has the highest priority.
   function automatic logic [2:0] topLevel(input logic [7:0] vec);
      logic [2:0] lvl;
      lvl = `IAVS_DROP_LEVEL;
      for (int i = 7; i >= 0; i--)
      begin
         if (vec[i])
         begin
            lvl = 3'(i);
         end
      end
      return lvl;
   endfunction : topLevel

   // Levels strictly above the highest level now in service.
   function automatic logic [7:0] aboveService(input logic [7:0] in_service_bits);
      logic [7:0] ok;
      logic blocked;
      ok = `IAVS_RST_BYTE;
      blocked = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         blocked = blocked | in_service_bits[i];
         ok[i] = !blocked;
      end
      return ok;
   endfunction : aboveService

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers and edge detection.

   logic [7:0] reqSync;
   logic [7:0] reqPrev_q;
   logic ackSync;
   logic ackPrev_q;
   logic ackLead;
   logic ackTrail;

   iavs_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_reqSync
   (
      .clk(clk),
      .rstn(rstn),
      .async_in(request_input),
      .sync_out(reqSync)
   );

   iavs_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_ackSync
   (
      .clk(clk),
      .rstn(rstn),
      .async_in(irq_ack_pulse_n),
      .sync_out(ackSync)
   );

   // Edges are taken from the synchronised copies only.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reqPrev_q <= `IAVS_RST_BYTE;
         ackPrev_q <= 1'b1;
      end
      else
      begin
         reqPrev_q <= reqSync;
         ackPrev_q <= ackSync;
      end
   end

   assign ackLead = ackPrev_q && !ackSync; // [R19]
   assign ackTrail = !ackPrev_q && ackSync; // [R19]

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers and bus slave.

   iavs_word_one_t wordOne_q;
   logic [7:0] wordTwo_q;
   iavs_word_four_t wordFour_q;
   logic [7:0] mask_q;
   iavs_addr_phase_t aph_q;
   logic readPend_q;
   logic addrTaken;
   logic busWrite;
   logic [31:0] statusWord;
   logic [31:0] readMux;

   assign addrTaken = hsel && hready && htrans[`IAVS_HTRANS_NONSEQ_BIT];
   assign busWrite = aph_q.valid && aph_q.write;

   // Address phase is captured; reads get one wait state so that a write
   // in the previous data phase is always visible to them.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         aph_q <= '0;
         readPend_q <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= `IAVS_HRESP_OKAY;
         hrdata <= `IAVS_RST_WORD;
      end
      else
      begin
         aph_q <= '{addr: haddr[7:0], write: hwrite, valid: addrTaken};
         readPend_q <= addrTaken && !hwrite;
         hreadyout <= !(addrTaken && !hwrite);
         hresp <= `IAVS_HRESP_OKAY;
         if (readPend_q)
         begin
            hrdata <= readMux;
         end
      end
   end

   // Writes land at the end of their data phase; unmapped ones are dropped.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         wordOne_q <= '0;
         wordTwo_q <= `IAVS_RST_BYTE;
         wordFour_q <= '0;
         mask_q <= `IAVS_RST_BYTE;
      end
      else if (busWrite)
      begin
         case (aph_q.addr)
            `IAVS_OFS_INIT_ONE:
            begin
               wordOne_q.addrLow <=
                  hwdata[`IAVS_W1_ADDR_HI:`IAVS_W1_ADDR_LO]; // [R17]
               wordOne_q.spacingFour <= hwdata[`IAVS_W1_SPACING]; // [R17]
               wordOne_q.needWordFour <= hwdata[`IAVS_W1_NEED_FOUR];
               mask_q <= `IAVS_RST_BYTE;
               if (!hwdata[`IAVS_W1_NEED_FOUR])
               begin
                  wordFour_q <= '0; // [R15]
               end
            end
            `IAVS_OFS_INIT_TWO: wordTwo_q <= hwdata[7:0]; // [R16]
            `IAVS_OFS_INIT_FOUR:
            begin
               if (wordOne_q.needWordFour)
               begin
                  wordFour_q.autoEndOfService <=
                     hwdata[`IAVS_W4_AUTO_EOS]; // [R15]
                  wordFour_q.pointerMode <= hwdata[`IAVS_W4_POINTER];
               end
            end
            `IAVS_OFS_MASK: mask_q <= hwdata[7:0];
            default: mask_q <= mask_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request latch, priority and interrupt output.

   logic [7:0] irr_q;
   logic [7:0] isr_q;
   logic [7:0] qualify;
   logic [7:0] svcClear;
   logic [7:0] svcSet;
   logic [7:0] eosClear;
   logic [2:0] level_q;
   logic svcValid_q;
   logic [1:0] cnt_q;
   logic [1:0] lastPulse;
   iavs_state_t state_q;

   assign qualify = irr_q & ~mask_q & aboveService(isr_q); // [R2] [R18]
   assign lastPulse = wordFour_q.pointerMode ? `IAVS_PTR_PULSES
                                             : `IAVS_CALL_PULSES;

   // A new rising request wins over a service clear in the same cycle;
   // a bit drops once its input falls, which is what turns an early
   // release into the level 7 answer below.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         irr_q <= `IAVS_RST_BYTE;
      end
      else
      begin
         irr_q <= ((irr_q & ~svcClear) | (reqSync & ~reqPrev_q))
                  & reqSync; // [R1] [R7]
      end
   end

   // The output is held low during an acknowledge sequence.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         intOut <= 1'b0;
      end
      else
      begin
         intOut <= (state_q == IAVS_ST_IDLE) && (qualify != '0); // [R2]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Acknowledge sequencer.

   // Pulses are counted on leading edges; the count returns to zero at the
   // trailing edge of the last pulse of the current mode.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= IAVS_ST_IDLE;
         cnt_q <= `IAVS_CNT_ZERO;
         level_q <= `IAVS_DROP_LEVEL;
         svcValid_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            IAVS_ST_IDLE, IAVS_ST_GAP:
            begin
               if (ackLead)
               begin
                  state_q <= IAVS_ST_PULSE;
                  cnt_q <= cnt_q + 2'h1; // [R19]
                  if (cnt_q == `IAVS_CNT_ZERO)
                  begin
                     level_q <= topLevel(qualify); // [R18] [R14]
                     svcValid_q <= (qualify != '0); // [R14]
                  end
               end
            end
            IAVS_ST_PULSE:
            begin
               if (ackTrail)
               begin
                  if (cnt_q == lastPulse)
                  begin
                     state_q <= IAVS_ST_IDLE;
                     cnt_q <= `IAVS_CNT_ZERO; // [R19]
                  end
                  else
                  begin
                     state_q <= IAVS_ST_GAP;
                  end
               end
            end
            default:
            begin
               state_q <= IAVS_ST_IDLE;
               cnt_q <= `IAVS_CNT_ZERO;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data bus bytes.

   logic [1:0] nextCnt;
   logic [7:0] lowByte;
   logic [7:0] pointerByte;
   logic [2:0] curLevel;

   assign nextCnt = cnt_q + 2'h1;
   // The level is frozen at the first pulse and used for later bytes.
   assign curLevel = (cnt_q == `IAVS_CNT_ZERO) ? topLevel(qualify) : level_q;
   assign lowByte = wordOne_q.spacingFour
      ? {wordOne_q.addrLow, curLevel, 2'b00} // [R5]
      : {wordOne_q.addrLow[2:1], curLevel, 3'b000}; // [R5]
   assign pointerByte = {wordTwo_q[7:3], curLevel}; // [R11]

   // Drive starts at the leading edge and stops at the trailing edge.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dataOut <= `IAVS_RST_BYTE;
         dataOe <= 1'b0;
      end
      else if (ackLead && state_q != IAVS_ST_PULSE)
      begin
         if (wordFour_q.pointerMode)
         begin
            dataOe <= (nextCnt == `IAVS_PULSE_TWO); // [R9] [R10]
            dataOut <= pointerByte; // [R10]
         end
         else
         begin
            dataOe <= 1'b1;
            case (nextCnt)
               `IAVS_PULSE_ONE: dataOut <= `IAVS_CALL_OPCODE; // [R3]
               `IAVS_PULSE_TWO: dataOut <= lowByte; // [R4]
               `IAVS_PULSE_THREE: dataOut <= wordTwo_q; // [R4] [R6]
               default: dataOut <= `IAVS_RST_BYTE;
            endcase
         end
      end
      else if (ackTrail)
      begin
         dataOe <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // In-service bits.

   logic lastLead;
   logic lastTrail;

   assign lastLead = ackLead && state_q != IAVS_ST_PULSE
                     && nextCnt == lastPulse;
   assign lastTrail = ackTrail && state_q == IAVS_ST_PULSE
                      && cnt_q == lastPulse;
   assign svcSet = (lastLead && svcValid_q) ? 8'(1 << level_q)
                                            : `IAVS_RST_BYTE; // [R7] [R14]
   assign svcClear = svcSet;
   assign eosClear = (busWrite && aph_q.addr == `IAVS_OFS_EOS_CMD)
                     ? hwdata[7:0] : `IAVS_RST_BYTE;

   // Setting wins over any clear that meets it in the same cycle.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         isr_q <= `IAVS_RST_BYTE;
      end
      else
      begin
         isr_q <= (isr_q & ~eosClear
                   & ~((lastTrail && svcValid_q && wordFour_q.autoEndOfService)
                       ? 8'(1 << level_q) : `IAVS_RST_BYTE)) // [R8] [R12]
                  | svcSet; // [R7]
      end
   end

   assign statusWord = {8'h00, 2'b00, state_q, intOut, level_q, isr_q, irr_q};

   // Register read decode; unmapped and write-only offsets read zero.
   always_comb
   begin
      case (aph_q.addr)
         `IAVS_OFS_INIT_ONE: readMux = {24'h0, wordOne_q.addrLow, 2'b00,
                                        wordOne_q.spacingFour, 1'b0,
                                        wordOne_q.needWordFour};
         `IAVS_OFS_INIT_TWO: readMux = {24'h0, wordTwo_q};
         `IAVS_OFS_INIT_FOUR: readMux = {30'h0, wordFour_q};
         `IAVS_OFS_MASK: readMux = {24'h0, mask_q};
         `IAVS_OFS_STATUS: readMux = statusWord;
         default: readMux = `IAVS_RST_WORD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence firstLead;
      ackLead && state_q == IAVS_ST_IDLE;
   endsequence

   sequence leadAt(logic [1:0] n);
      ackLead && state_q != IAVS_ST_PULSE && cnt_q == n;
   endsequence

   AST_REQ_SET: assert property (@(posedge clk) disable iff (!rstn) // [R1]
      (reqSync & ~reqPrev_q) != '0 |=>
         ((irr_q & $past(reqSync & ~reqPrev_q))
            == $past(reqSync & ~reqPrev_q)))
      else $error("Rising request did not set its latch bit.");

   AST_INT_QUAL: assert property (@(posedge clk) disable iff (!rstn) // [R2]
      $rose(intOut) |-> $past(qualify != '0) && $past(state_q == IAVS_ST_IDLE))
      else $error("Interrupt output rose without a qualifying request.");

   AST_CALL_OPCODE: assert property (@(posedge clk) disable iff (!rstn) // [R3]
      firstLead and !wordFour_q.pointerMode |=>
         dataOe && dataOut == `IAVS_CALL_OPCODE)
      else $error("First call pulse did not drive the call opcode.");

   AST_LOW_BYTE: assert property (@(posedge clk) disable iff (!rstn) // [R5]
      leadAt(`IAVS_PULSE_ONE) and !wordFour_q.pointerMode |=>
         dataOe && dataOut == $past(lowByte))
      else $error("Second call pulse drove a wrong low vector byte.");

   AST_HIGH_BYTE: assert property (@(posedge clk) disable iff (!rstn) // [R6]
      leadAt(`IAVS_PULSE_TWO) and !wordFour_q.pointerMode |=>
         dataOe && dataOut == $past(wordTwo_q))
      else $error("Third call pulse drove a wrong high vector byte.");

   AST_SVC_SET: assert property (@(posedge clk) disable iff (!rstn) // [R7]
      lastLead && svcValid_q |=> isr_q[$past(level_q)])
      else $error("Last pulse did not set the in-service bit.");

   AST_AUTO_END: assert property (@(posedge clk) disable iff (!rstn) // [R8]
      lastTrail && svcValid_q && wordFour_q.autoEndOfService
         && svcSet == '0 |=> !isr_q[$past(level_q)])
      else $error("Automatic end did not clear the in-service bit.");

   AST_PTR_HIZ: assert property (@(posedge clk) disable iff (!rstn) // [R9]
      firstLead and wordFour_q.pointerMode |=> !dataOe [*2])
      else $error("Pointer mode drove the bus on the first pulse.");

   AST_PTR_BYTE: assert property (@(posedge clk) disable iff (!rstn) // [R11]
      leadAt(`IAVS_PULSE_ONE) and wordFour_q.pointerMode |=>
         dataOe && dataOut == {$past(wordTwo_q[7:3]), $past(level_q)})
      else $error("Pointer byte is wrong.");

   AST_DROP_L7: assert property (@(posedge clk) disable iff (!rstn) // [R14]
      firstLead and qualify == '0 |=>
         level_q == `IAVS_DROP_LEVEL && !svcValid_q)
      else $error("Dropped request not answered as unserved level 7.");

endmodule : iavs_sequencer

`default_nettype wire

//--- iavs_host_model.sv
/*
 * Processor model on the far side of the acknowledge link: it issues
 * acknowledge pulses and reads the byte seen on the shared data bus.
 * Assumes it is called right after a rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none

module iavs_host_model
   import iavs_pkg::*;
(
   input wire logic clk,
   output logic irq_ack_pulse_n,
   input wire logic [7:0] dataOut,
   input wire logic dataOe
);

   logic [7:0] dataBus;

   ////////////////////////////////////////////////////////////////////////
   // The processor sees the bus float whenever the block is not driving.
   assign dataBus = dataOe ? dataOut : 8'hZZ;

   // The acknowledge pin idles high between sequences.
   initial irq_ack_pulse_n = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // One sequence of pulses; each is held low and high long enough for the
   // two flip-flop synchroniser, and the bus is read just before release.
   task automatic ack(input int pulses, input int lowCyc,
                      output logic [23:0] got);
      got = '0;
      for (int p = 0; p < pulses; p++)
      begin
         irq_ack_pulse_n <= 1'b0;
         repeat (lowCyc) @(posedge clk);
         @(negedge clk);
         got = {got[15:0], dataBus};
         @(posedge clk);
         irq_ack_pulse_n <= 1'b1;
         repeat (6) @(posedge clk);
      end
   endtask : ack

endmodule : iavs_host_model

`default_nettype wire

//--- iavs_sequencer_test.sv
/*
 * Self-checking testbench of the acknowledge sequencer: registers are set
 * over AHB-Lite, requests are raised and the processor model acknowledges.
 * Assumes iavs_defs.svh on the include path and the host model compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iavs_defs.svh"

module iavs_sequencer_test
   import iavs_pkg::*;
;

   logic clk;
   logic rstn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic [7:0] reqIn;
   logic ackN;
   logic intOut;
   logic [7:0] dataOut;
   logic dataOe;
   logic [31:0] rdData;
   int nFail;
   int samplesChecked;

   ////////////////////////////////////////////////////////////////////////
   // The single slave's ready is the bus ready.
   iavs_sequencer iavs_sequencer_inst
   (
      .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .request_input(reqIn), .irq_ack_pulse_n(ackN), .intOut(intOut),
      .dataOut(dataOut), .dataOe(dataOe)
   );

   iavs_host_model iavs_host_model_inst
   (
      .clk(clk), .irq_ack_pulse_n(ackN), .dataOut(dataOut), .dataOe(dataOe)
   );

   // Free-running 10 MHz clock.
   initial clk = 1'b0;
   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Verdict; the only place where the run ends.
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // Case equality, so an unknown counts as a match only against the same unknown in the expected value.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         nFail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // A wait that never ends is cut short and counted as a mismatch.
   task automatic expire;
      chk(32'h0000_0000, 32'h0000_0001);
      tally_and_finish();
   endtask : expire

   // Ready is looked at where settled, then taken at the next rising edge.
   task automatic waitReady;
      int k;
      k = 0;
      @(negedge clk);
      while (hreadyout !== 1'b1)
      begin
         k++;
         if (k > 20)
            expire();
         @(negedge clk);
      end
      rdData = hrdata;
      chk({31'h0000_0000, hresp}, 32'h0000_0000); // Always OKAY.
      @(posedge clk);
   endtask : waitReady

   // One single word transfer: address phase, then data phase.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
   endtask : bus

   // Bounded wait for the interrupt output.
   task automatic waitInt;
      int k;
      k = 0;
      @(negedge clk);
      while (intOut !== 1'b1)
      begin
         k++;
         if (k > 20)
            expire();
         @(negedge clk);
      end
      @(posedge clk);
   endtask : waitInt

   // Full acknowledge sequence, then the in-service bits from status.
   task automatic serve(input int pulses, input int lowCyc,
                        input logic drop, input logic [23:0] exp,
                        input logic [7:0] inService);
      logic [23:0] got;
      waitInt();
      // The request must be gone through its synchroniser before the
      // leading edge is seen, or the drop would pass unnoticed.
      if (drop)
      begin
         reqIn <= 8'h00;
         repeat (4) @(posedge clk);
      end
      iavs_host_model_inst.ack(pulses, lowCyc, got);
      chk({8'h00, got}, {8'h00, exp});
      bus(1'b0, `IAVS_OFS_STATUS, 32'h0000_0000);
      chk({24'h00_0000, rdData[15:8]}, {24'h00_0000, inService});
   endtask : serve

   ////////////////////////////////////////////////////////////////////////
   // Call mode, spacing 4: two requests, the higher one served first.
   task automatic call_spacing_four;
      bus(1'b1, `IAVS_OFS_INIT_ONE, 32'h0000_00A5);
      bus(1'b1, `IAVS_OFS_INIT_TWO, 32'h0000_003C);
      bus(1'b1, `IAVS_OFS_INIT_FOUR, 32'h0000_0000);
      reqIn <= 8'h28;
      serve(3, 6, 1'b0, 24'hCD_AC_3C, 8'h08);
      chk({24'h00_0000, rdData[7:0]}, 32'h0000_0020);
      reqIn <= 8'h20;
      bus(1'b1, `IAVS_OFS_EOS_CMD, 32'h0000_0008);
      serve(3, 12, 1'b0, 24'hCD_B4_3C, 8'h20);
      reqIn <= 8'h00;
      bus(1'b1, `IAVS_OFS_EOS_CMD, 32'h0000_0020);
   endtask : call_spacing_four

   // Word four is refused unless asked for; masked request stays silent;
   // spacing 8 with automatic end.
   task automatic call_spacing_eight;
      bus(1'b1, `IAVS_OFS_INIT_ONE, 32'h0000_0000);
      bus(1'b1, `IAVS_OFS_INIT_FOUR, 32'h0000_0003);
      bus(1'b0, `IAVS_OFS_INIT_FOUR, 32'h0000_0000);
      chk(rdData, 32'h0000_0000);
      bus(1'b1, `IAVS_OFS_INIT_ONE, 32'h0000_00C1);
      bus(1'b1, `IAVS_OFS_INIT_TWO, 32'h0000_0081);
      bus(1'b1, `IAVS_OFS_INIT_FOUR, 32'h0000_0002);
      bus(1'b1, `IAVS_OFS_MASK, 32'h0000_0040);
      reqIn <= 8'h40;
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk({31'h0, intOut}, 32'h0000_0000);
      @(posedge clk);
      bus(1'b1, `IAVS_OFS_MASK, 32'h0000_0000);
      serve(3, 6, 1'b0, 24'hCD_F0_81, 8'h00);
      reqIn <= 8'h00;
   endtask : call_spacing_eight

   // Pointer mode with automatic end, every level in turn; the low type
   // bits are written as ones to show that the level replaces them.
   task automatic pointer_all_levels;
      logic [23:0] ptrExp;
      bus(1'b1, `IAVS_OFS_INIT_ONE, 32'h0000_0001);
      bus(1'b1, `IAVS_OFS_INIT_TWO, 32'h0000_004F);
      bus(1'b1, `IAVS_OFS_INIT_FOUR, 32'h0000_0003);
      for (int l = 0; l < 8; l++)
      begin
         reqIn <= 8'h01 << l;
         ptrExp = {16'h00ZZ, 5'h09, 3'(l)};
         serve(2, 6, 1'b0, ptrExp, 8'h00);
      end
      reqIn <= 8'h00;
   endtask : pointer_all_levels

   // Request dropped before the first pulse: level 7 and nothing served.
   task automatic early_drop;
      bus(1'b1, `IAVS_OFS_INIT_FOUR, 32'h0000_0001);
      reqIn <= 8'h10;
      serve(2, 6, 1'b1, 24'h00_ZZ_4F, 8'h00);
   endtask : early_drop

   ////////////////////////////////////////////////////////////////////////
   // Reset for 16 cycles, then the scenarios in order.
   initial
   begin
      nFail = 0;
      samplesChecked = 0;
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      reqIn = 8'h00;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      call_spacing_four();
      call_spacing_eight();
      pointer_all_levels();
      early_drop();
      tally_and_finish();
   end

endmodule : iavs_sequencer_test

`default_nettype wire
